//--- core/hbw_write_target.sv
// Target protocol engine for single-byte writes on the nibble bus
//
// Overview of operation
// R1: Start 1110 with strobe low; last one counts
// R2: Respond only if select nibble equals straps
// R3: Seven address nibbles, most significant first
// R4: Size nibble must be 0000, single byte
// R5: Bad size resets engine, no response
// R6: Data low nibble cycle 11, high 12
// R7: Host drives 1111 then floats, cycle 13
// R8: Device owns bus in cycle 14
// R9: Device drives ready sync 0000, cycle 15
// R10: Device drives 1111 then floats, cycle 16
// R11: Fields sampled on rising edge of cycle
// R12: No explicit signal of invalid fields
// R13: Decode low 20 bits; small density drops bit19
// R14: Bit 22 selects flash array or registers
// R15: Misaligned multibyte reads return aligned followers
// R16: After valid header, later inputs taken as valid
// R17: Flash command bytes passed without checking
// R18: Strobe low releases outputs, resets engine
// R19: Running program or erase survives the strobe
// R20: No flash operation before final data nibble
// R21: Unselected device floats until next start
`timescale 1ns/1ns
module hbw_write_target
    import hbw_pkg::*;
#(
    parameter bit DENSITY_SMALL = 1'b0   // 1: small density part
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    // Nibble bus link
    input  wire logic        FRAME_STROBE_N_I,
    input  wire logic [3:0]  NIBBLE_BUS_I,
    output logic      [3:0]  NIBBLE_BUS_O,
    output logic             NIBBLE_BUS_OE_N_O,
    // Identity straps
    input  wire logic [3:0]  IDENTITY_STRAPS_I,
    // Write request to the flash side
    output logic             WR_VALID_O,
    output hbw_wr_req_s      WR_REQ_O,
    // Status
    output logic             TXN_ACTIVE_O
);

    hbw_state_e      state_q;
    hbw_state_e      state_d;
    logic [2:0]      cnt_q;
    logic [2:0]      cnt_d;
    logic [3:0]      dlo_q;
    logic [3:0]      drv_q;
    logic [3:0]      drv_d;
    logic            oe_n_q;
    logic            oe_n_d;
    logic            wr_valid_q;
    hbw_wr_req_s     wr_req_q;
    hbw_wr_req_s     wr_req_d;
    logic [3:0]      straps;
    logic [ADDR_BITS-1:0] addr_word;
    logic [DEC_BITS-1:0]  addr_dec;
    logic            frame_hi;
    logic            start_seen;
    logic            sel_match;
    logic            size_ok;
    logic            addr_shift;
    logic            last_nib;

    // Straps are static pins from outside the clock domain
    hbw_sync2 #(
        .WIDTH   (4)
    ) u_strap_sync (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .level_i (IDENTITY_STRAPS_I),
        .level_o (straps)
    );

    // Address nibbles gathered as they arrive
    hbw_nib_shift #(
        .WIDTH   (ADDR_BITS)
    ) u_addr_shift (
        .clk_i   (CLK_I),
        .rst_i   (RST_I),
        .shift_i (addr_shift),
        .nib_i   (NIBBLE_BUS_I),
        .word_o  (addr_word)
    );

    // Field decodes on the sampled bus
    assign frame_hi   = FRAME_STROBE_N_I;
    assign start_seen = (NIBBLE_BUS_I == START_WRITE);   // R1
    assign sel_match  = (NIBBLE_BUS_I == straps);        // R2
    assign size_ok    = (NIBBLE_BUS_I == SIZE_ONE);      // R4 R15
    assign addr_shift = frame_hi && (state_q == ST_ADDR); // R3 R11
    assign last_nib   = (cnt_q == ADDR_LAST);

    // Decoded address, upper bits dropped
    assign addr_dec = DENSITY_SMALL ?
                      {1'b0, addr_word[DENS_TOP_BIT-1:0]} :   // R13
                      addr_word[DEC_BITS-1:0];                // R13

    // Next state; the strobe low overrides every state
    always_comb begin
        state_d = state_q;
        cnt_d   = CNT_RESET;
        if (!frame_hi) begin
            state_d = start_seen ? ST_START : ST_IDLE;   // R1 R18
        end else begin
            case (state_q)
                ST_IDLE: begin
                    state_d = ST_IDLE;
                end
                ST_START: begin
                    state_d = sel_match ? ST_ADDR : ST_SKIP;   // R2 R21
                end
                ST_ADDR: begin
                    cnt_d   = cnt_q + 3'h1;
                    state_d = last_nib ? ST_SIZE : ST_ADDR;     // R3
                end
                ST_SIZE: begin
                    state_d = size_ok ? ST_DLO : ST_IDLE;       // R4 R5
                end
                ST_DLO: begin
                    state_d = ST_DHI;                           // R6 R16
                end
                ST_DHI: begin
                    state_d = ST_HREL;                          // R6
                end
                ST_HREL: begin
                    state_d = ST_DTAK;                          // R7
                end
                ST_DTAK: begin
                    state_d = ST_SYNC;                          // R8
                end
                ST_SYNC: begin
                    state_d = ST_TARD;                          // R9
                end
                ST_TARD: begin
                    state_d = ST_IDLE;                          // R10
                end
                ST_SKIP: begin
                    state_d = ST_SKIP;                          // R21
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    // Output drive follows the state being entered
    always_comb begin
        drv_d  = TAR_ONES;
        oe_n_d = 1'b1;
        case (state_d)
            ST_SYNC: begin
                drv_d  = READY_SYNC;   // R9
                oe_n_d = 1'b0;         // R8
            end
            ST_TARD: begin
                drv_d  = TAR_ONES;     // R10
                oe_n_d = 1'b0;
            end
            default: begin
                drv_d  = TAR_ONES;
                oe_n_d = 1'b1;         // R12 R21
            end
        endcase
    end

    // Write request formed from the final nibble; data passes unchecked
    assign wr_req_d = '{core_sel: addr_word[CORE_SEL_BIT],   // R14
                        addr:     addr_dec,                  // R13
                        data:     {NIBBLE_BUS_I, dlo_q}};    // R6 R17

    // State and counter
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_RESET;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Bus drive registers
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            drv_q  <= DRV_RESET;
            oe_n_q <= 1'b1;
        end else begin
            drv_q  <= drv_d;
            oe_n_q <= oe_n_d;
        end
    end

    // Low data nibble capture
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            dlo_q <= 4'h0;
        end else if (frame_hi && state_q == ST_DLO) begin
            dlo_q <= NIBBLE_BUS_I;   // R6
        end
    end

    // Write handed over only once the high nibble is in
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wr_valid_q <= 1'b0;
            wr_req_q   <= '0;
        end else begin
            wr_valid_q <= frame_hi && (state_q == ST_DHI);   // R20
            if (frame_hi && state_q == ST_DHI) begin
                wr_req_q <= wr_req_d;
            end
        end
    end

    // Strobe low floats the bus at once; nothing here stops a running flash job
    assign NIBBLE_BUS_OE_N_O = oe_n_q | ~FRAME_STROBE_N_I;   // R18 R19
    assign NIBBLE_BUS_O      = drv_q;
    assign WR_VALID_O        = wr_valid_q;
    assign WR_REQ_O          = wr_req_q;
    assign TXN_ACTIVE_O      = (state_q != ST_IDLE) && (state_q != ST_SKIP);

    // Last start before the strobe rises is the one that counts
    property p_start_latch;
        @(posedge CLK_I) disable iff (RST_I)
        (!FRAME_STROBE_N_I && NIBBLE_BUS_I == START_WRITE) |=> (state_q == ST_START);
    endproperty
    a_start_latch: assert property (p_start_latch)   // R1
        else $error("start field not latched");

    // Mismatched select parks the engine and keeps the bus floating
    property p_sel_miss;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_START && frame_hi && NIBBLE_BUS_I != straps)
        |=> (state_q == ST_SKIP && oe_n_q);
    endproperty
    a_sel_miss: assert property (p_sel_miss)   // R21
        else $error("unselected device left skip path");

    // Matching select leads to seven address cycles then size
    property p_addr_len;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_START && frame_hi && NIBBLE_BUS_I == straps) ##1 frame_hi [*7]
        |=> (state_q == ST_SIZE);
    endproperty
    a_addr_len: assert property (p_addr_len)   // R3
        else $error("address phase length wrong");

    // Bad size gives no write and no drive
    property p_bad_size;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_SIZE && frame_hi && NIBBLE_BUS_I != SIZE_ONE)
        |=> (state_q == ST_IDLE) ##0 (!WR_VALID_O && oe_n_q) [*6];
    endproperty
    a_bad_size: assert property (p_bad_size)   // R5
        else $error("bad size not dropped");

    // Write pulse carries both data nibbles in order
    property p_wr_data;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_DLO && frame_hi) ##1 (state_q == ST_DHI && frame_hi)
        |=> (WR_VALID_O && WR_REQ_O.data == {$past(NIBBLE_BUS_I), $past(NIBBLE_BUS_I, 2)});
    endproperty
    a_wr_data: assert property (p_wr_data)   // R6
        else $error("write byte mis-assembled");

    // No write without the high nibble taken under a high strobe
    property p_no_early_wr;
        @(posedge CLK_I) disable iff (RST_I)
        WR_VALID_O |-> ($past(state_q) == ST_DHI && $past(FRAME_STROBE_N_I));
    endproperty
    a_no_early_wr: assert property (p_no_early_wr)   // R20
        else $error("write issued before final nibble");

    // Host turnaround: device still floats, then ready sync is driven
    property p_turnaround;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_HREL && frame_hi) ##1 frame_hi ##1 frame_hi
        |-> (drv_q == READY_SYNC && !oe_n_q && $past(oe_n_q, 2));
    endproperty
    a_turnaround: assert property (p_turnaround)   // R8
        else $error("ready sync not driven after turnaround");

    // Ones after the sync, then the bus is released
    property p_release;
        @(posedge CLK_I) disable iff (RST_I)
        (state_q == ST_SYNC && frame_hi)
        |=> (drv_q == TAR_ONES && !oe_n_q) ##1 oe_n_q;
    endproperty
    a_release: assert property (p_release)   // R10
        else $error("bus not handed back after sync");

    // Strobe low floats the outputs and restarts the engine
    property p_abort;
        @(posedge CLK_I) disable iff (RST_I)
        !FRAME_STROBE_N_I |-> NIBBLE_BUS_OE_N_O ##1
            (state_q == ST_IDLE || state_q == ST_START);
    endproperty
    a_abort: assert property (p_abort)   // R18
        else $error("abort did not release the bus");

    // Small density never reports the dropped address bit
    property p_density;
        @(posedge CLK_I) disable iff (RST_I)
        (WR_VALID_O && DENSITY_SMALL) |-> (WR_REQ_O.addr[DENS_TOP_BIT] == 1'b0);
    endproperty
    a_density: assert property (p_density)   // R13
        else $error("dropped address bit leaked");

    // Select bit follows address bit 22
    property p_core_sel;
        @(posedge CLK_I) disable iff (RST_I)
        WR_VALID_O |-> (WR_REQ_O.core_sel == $past(addr_word[CORE_SEL_BIT]));
    endproperty
    a_core_sel: assert property (p_core_sel)   // R14
        else $error("core select bit wrong");

endmodule : hbw_write_target

//--- common/hbw_pkg.sv
// Shared constants, state encoding and carriers of the nibble bus write target
package hbw_pkg;

    // Field codes seen on or driven onto the nibble bus
    localparam logic [3:0] START_WRITE  = 4'he;   // Write start field
    localparam logic [3:0] SIZE_ONE     = 4'h0;   // Only accepted transfer size
    localparam logic [3:0] READY_SYNC   = 4'h0;   // Ready sync answer
    localparam logic [3:0] TAR_ONES     = 4'hf;   // Turnaround drive level

    // Address field layout
    localparam int         ADDR_NIBBLES = 7;      // Address nibbles on the bus
    localparam int         ADDR_BITS    = 28;     // Full bus address width
    localparam int         DEC_BITS     = 20;     // Address bits actually decoded
    localparam int         CORE_SEL_BIT = 22;     // Core or register select bit
    localparam int         DENS_TOP_BIT = 19;     // Bit dropped at the small density
    localparam logic [2:0] ADDR_LAST    = 3'h6;   // Index of last address nibble

    // Values after reset
    localparam logic [3:0] DRV_RESET    = 4'hf;   // Output nibble after reset
    localparam logic [2:0] CNT_RESET    = 3'h0;   // Address counter after reset

    // Transaction states, Gray coded along the write path from ST_IDLE to ST_TARD
    typedef enum logic [3:0] {
        ST_IDLE  = 4'h0,   // Bus not owned, waiting for a start field
        ST_START = 4'h1,   // Start seen, device select field follows
        ST_ADDR  = 4'h3,   // Collecting address nibbles
        ST_SIZE  = 4'h2,   // Transfer size field
        ST_DLO   = 4'h6,   // Low data nibble
        ST_DHI   = 4'h7,   // High data nibble
        ST_HREL  = 4'h5,   // Host drives ones, then floats
        ST_DTAK  = 4'h4,   // Bus handed to the device
        ST_SYNC  = 4'hc,   // Ready sync driven
        ST_TARD  = 4'hd,   // Device drives ones, then floats
        ST_SKIP  = 4'hf    // Not selected, ignore until next start
    } hbw_state_e;

    // One accepted write handed to the flash side
    typedef struct packed {
        logic                core_sel;   // 1: flash array, 0: register space
        logic [DEC_BITS-1:0] addr;       // Decoded target address
        logic [7:0]          data;       // Program data or flash command
    } hbw_wr_req_s;

endpackage : hbw_pkg

//--- core/hbw_sync2.sv
// Two flip-flop synchroniser for slow pin levels
`timescale 1ns/1ns
module hbw_sync2 #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Level in and synchronised level out
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= level_i;
            sync_q <= meta_q;
        end
    end

    assign level_o = sync_q;

endmodule : hbw_sync2

//--- core/hbw_nib_shift.sv
// Shift register that gathers address nibbles, most significant first
`timescale 1ns/1ns
module hbw_nib_shift #(
    parameter int WIDTH = 28
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Nibble input and shift strobe
    input  wire logic             shift_i,
    input  wire logic [3:0]       nib_i,
    // Assembled word
    output logic      [WIDTH-1:0] word_o
);

    logic [WIDTH-1:0] word_q;
    logic [WIDTH-1:0] word_d;

    // Earlier nibbles move toward the top
    assign word_d = shift_i ? {word_q[WIDTH-5:0], nib_i} : word_q;

    // Storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_q <= '0;
        end else begin
            word_q <= word_d;
        end
    end

    assign word_o = word_q;

endmodule : hbw_nib_shift

//--- test/hbw_host_model.sv
// Host bus controller model that drives write frames onto the nibble bus
`timescale 1ns/1ns
module hbw_host_model (
    // Clock
    input  wire logic       clk_i,
    // Host drive and cycle number of the frame
    output logic            strobe_n_o,
    output logic      [3:0] nib_o,
    output int              cyc_o
);
    // Idle host: strobe high, released bus
    initial begin
        strobe_n_o = 1'b1;
        nib_o      = 4'h5;
        cyc_o      = 0;
    end

    // Idle cycles; a released line shows a changing pattern
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_i);
            nib_o <= ~nib_o;
            cyc_o  = 0;
        end
    endtask : idle

    // One frame: pre cycle, cycles 1..17; ab > 0 aborts in that cycle
    task automatic frame(input logic [3:0] pre, st, sel, input logic [27:0] a,
                         input logic [3:0] size, input logic [7:0] d, input int ab);
        logic [3:0] f;
        for (int c = 0; c <= 17; c++) begin
            case (c)
                0:       f = pre;
                1:       f = st;
                2:       f = sel;
                10:      f = size;
                11:      f = d[3:0];
                12:      f = d[7:4];
                13:      f = 4'hf;
                default: f = (c < 10) ? a[4*(9-c) +: 4] : ~nib_o;
            endcase
            @(posedge clk_i);
            strobe_n_o <= !(c <= 1 || (ab > 0 && c == ab));
            nib_o      <= (ab > 0 && c == ab) ? 4'h5 : f;
            cyc_o       = c;
        end
        @(negedge clk_i);
    endtask : frame
endmodule : hbw_host_model

//--- test/hbw_write_target_tb.sv
// Self-checking bench for the nibble bus write target
`timescale 1ns/1ns
module hbw_write_target_tb;
    import hbw_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  straps = 4'h0;
    logic        strobe_n;
    logic [3:0]  host_nib;
    logic [3:0]  dev_nib;
    logic [3:0]  bus_wire;
    logic        oe_n;
    logic        wr_valid;
    logic        active;
    hbw_wr_req_s wr_req;
    hbw_wr_req_s small_req;
    logic        small_valid;
    hbw_wr_req_s exp_r;
    hbw_wr_req_s exp_q [$];
    int          cyc;
    int          n_fail = 0;
    int          samples_checked = 0;
    integer      seed = 32'h9e8e16d2;
    logic [3:0]  g_st = 4'h0;
    logic [3:0]  g_pre = 4'h0;
    logic [3:0]  g_sel = 4'h0;
    logic [3:0]  g_size = 4'h0;
    int          g_ab = 0;
    logic        st_ok, sel_ok, ok, exp_drv, exp_act, exp_wr;

    // Clock at 50 ns
    initial forever #25 clk = ~clk;

    // Wire level from both drivers
    assign bus_wire = !oe_n ? dev_nib : host_nib;

    // Reference of the expected reply per cycle
    assign st_ok   = g_st == START_WRITE;
    assign sel_ok  = st_ok && g_sel == straps;
    assign ok      = sel_ok && g_size == SIZE_ONE;
    assign exp_drv = ok && (cyc == 15 || cyc == 16) && !(g_ab > 0 && g_ab <= cyc);
    assign exp_wr  = ok && cyc == 13 && !(g_ab > 0 && g_ab <= 12);
    assign exp_act = ((cyc == 1 && g_pre == START_WRITE) || (cyc == 2 && st_ok)
                     || (cyc >= 3 && cyc <= 10 && sel_ok)
                     || (cyc >= 11 && cyc <= 16 && ok)) && !(g_ab > 0 && g_ab < cyc);

    hbw_write_target dut (
        .CLK_I             (clk),
        .RST_I             (rst),
        .FRAME_STROBE_N_I  (strobe_n),
        .NIBBLE_BUS_I      (bus_wire),
        .NIBBLE_BUS_O      (dev_nib),
        .NIBBLE_BUS_OE_N_O (oe_n),
        .IDENTITY_STRAPS_I (straps),
        .WR_VALID_O        (wr_valid),
        .WR_REQ_O          (wr_req),
        .TXN_ACTIVE_O      (active)
    );

    // Small density copy, only its write request is watched
    hbw_write_target #(
        .DENSITY_SMALL     (1'b1)
    ) dut_small (
        .CLK_I             (clk),
        .RST_I             (rst),
        .FRAME_STROBE_N_I  (strobe_n),
        .NIBBLE_BUS_I      (bus_wire),
        .NIBBLE_BUS_O      (),
        .NIBBLE_BUS_OE_N_O (),
        .IDENTITY_STRAPS_I (straps),
        .WR_VALID_O        (small_valid),
        .WR_REQ_O          (small_req),
        .TXN_ACTIVE_O      ()
    );

    hbw_host_model host (
        .clk_i      (clk),
        .strobe_n_o (strobe_n),
        .nib_o      (host_nib),
        .cyc_o      (cyc)
    );

    // Count and report one comparison
    task automatic chk(input bit good, input string what);
        samples_checked++;
        if (!good) begin
            n_fail++;
            $display("BAD %0t %s in cycle %0d", $time, what, cyc);
        end
    endtask : chk

    // Print counts and verdict, then stop
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // One frame with its expected write queued
    task automatic run(input logic [3:0] pre, st, sel, size, input logic [27:0] a,
                       input logic [7:0] d, input int ab);
        #1;
        g_pre  = pre;
        g_st   = st;
        g_sel  = sel;
        g_size = size;
        g_ab   = ab;
        if (st == START_WRITE && sel == straps && size == SIZE_ONE && (ab == 0 || ab > 12))
            exp_q.push_back(hbw_wr_req_s'{a[CORE_SEL_BIT], a[DEC_BITS-1:0], d});
        host.frame(pre, st, sel, a, size, d, ab);
    endtask : run

    // New strap value, then time for its synchroniser
    task automatic set_straps(input logic [3:0] v);
        @(posedge clk);
        straps <= v;
        host.idle(3);
    endtask : set_straps

    // Mid-cycle comparison of every output with the reference
    always @(negedge clk) begin
        if (cyc > 0) begin
            chk(oe_n === !exp_drv, "drive enable");
            if (exp_drv) chk(bus_wire === (cyc == 15 ? READY_SYNC : TAR_ONES), "reply");
            chk(wr_valid === exp_wr, "write pulse");
            chk(active === exp_act, "active level");
            chk(small_valid === exp_wr, "small density write pulse");
        end
        if (wr_valid === 1'b1) begin
            exp_r = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            chk(wr_req === exp_r, "write request");
            exp_r.addr[DENS_TOP_BIT] = 1'b0;
            chk(small_req === exp_r, "small density request");
        end
    end

    // Bound on the whole run
    initial begin
        #1_000_000;
        n_fail++;
        $display("BAD %0t run did not finish", $time);
        end_sim();
    end

    // Main sequence
    initial begin
        logic [31:0] s;
        logic [31:0] t;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        set_straps(4'h9);
        run(4'h0, START_WRITE, 4'h9, SIZE_ONE, 28'h0412345, 8'ha5, 0);
        run(4'h0, START_WRITE, 4'h9, SIZE_ONE, 28'hfbfedcb, 8'h5a, 0);
        $display("test basic done");
        run(START_WRITE, 4'hd, 4'h9, SIZE_ONE, 28'h0400001, 8'h11, 0);
        run(4'hd, START_WRITE, 4'h9, SIZE_ONE, 28'h0400002, 8'h22, 0);
        $display("test start done");
        for (int z = 1; z < 16; z++)
            run(4'h0, START_WRITE, 4'h9, z[3:0], 28'h0400003, 8'h33, 0);
        $display("test size done");
        for (int a = 2; a <= 17; a++)
            run(4'h0, START_WRITE, 4'h9, SIZE_ONE, 28'h0412340, a[7:0], a);
        $display("test abort done");
        for (int i = 0; i < 60; i++) begin
            s = $random(seed);
            t = $random(seed);
            if (i % 20 == 0)
                set_straps(s[31:28]);
            run(4'h0, START_WRITE, s[0] ? straps : s[7:4], (s[9:8] != 0) ? SIZE_ONE : s[13:10],
                t[27:0], s[27:20], (s[17:16] != 0) ? 0 : 2 + int'(s[23:20]));
        end
        $display("test random done");
        chk(exp_q.size() == 0, "writes missing");
        end_sim();
    end
endmodule : hbw_write_target_tb
